// ---- rtl/ivs_defs.svh ----
`ifndef IVS_DEFS_SVH
`define IVS_DEFS_SVH

// Vector high-byte addresses: reset, software interrupt, one per source flag index, then reserved
`define IVS_VEC_RESET 16'hFFFE
`define IVS_VEC_SOFTWARE_INT 16'hFFFC
`define IVS_VEC_F01 16'hFFFA
`define IVS_VEC_F02 16'hFFF8
`define IVS_VEC_F03 16'hFFF6
`define IVS_VEC_F04 16'hFFF4
`define IVS_VEC_F05 16'hFFF2
`define IVS_VEC_F06 16'hFFF0
`define IVS_VEC_F07 16'hFFEE
`define IVS_VEC_F08 16'hFFEC
`define IVS_VEC_F09 16'hFFEA
`define IVS_VEC_F10 16'hFFE8
`define IVS_VEC_F11 16'hFFE6
`define IVS_VEC_F12 16'hFFE4
`define IVS_VEC_F13 16'hFFE2
`define IVS_VEC_F14 16'hFFE0
`define IVS_VEC_F15 16'hFFDE
`define IVS_VEC_F16 16'hFFDC
`define IVS_VEC_F17 16'hFFDA
`define IVS_VEC_F18 16'hFFD8
`define IVS_VEC_F19 16'hFFD6
`define IVS_VEC_F20 16'hFFD4
`define IVS_VEC_F21 16'hFFD2
`define IVS_VEC_RSVD 16'hFFD0

// Memory map and stack
`define IVS_RAM_BASE 16'h0060
`define IVS_SP_RESET 16'h00FF
`define IVS_PAGE0_TOP 16'h00FF
`define IVS_PAGE0_RAM_BYTES 160
`define IVS_INT_STACK_BYTES 3'h5
`define IVS_CALL_STACK_BYTES 3'h2
`define IVS_NUM_FLAGS 21

`endif

// ---- rtl/ivs_pkg.sv ----
package ivs_pkg;
  typedef enum logic [1:0] {IVS_IDLE, IVS_PUSH, IVS_VHI, IVS_VLO} ivs_state_e;
  // Stacking request from the core
  typedef struct packed {
    logic int_entry;
    logic software_interrupt;
    logic call;
    logic push;
    logic pull;
    logic [15:0] ret_addr;
  } ivs_req_s;
  // Memory bus toward the RAM/vector store
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ivs_mem_s;
endpackage

// ---- rtl/ivs_ram.sv ----
`timescale 1ns/1ns
`include "ivs_defs.svh"
module ivs_ram #(
  parameter int DEPTH = `IVS_PAGE0_RAM_BYTES,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  // Registered read, write-first free
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ---- rtl/ivs_ctrl.sv ----
`timescale 1ns/1ns
`include "ivs_defs.svh"
// Notes on behaviour
// - First timer overflow vector FFF0/FFF1, flag 6
// - First timer channels: FFF2 flag5, FFF4 flag4
// - Second timer vectors FFEA, FFEC, FFEE
// - Management bus vector FFE8/FFE9, flag 10
// - Serial port vectors FFE6, FFE4, FFE2
// - Keypad FFE0, converter FFDE
// - Serial peripheral receive FFDC, transmit FFDA
// - Infrared port FFD8..FFD4, time base FFD2
// - Sixteen-bit stack pointer, RAM from 0060
// - Stack pointer resets to 00FF
// - 160 bytes RAM in page zero
// - Interrupt entry pushes exactly five bytes
// - High index register never stacked
// - Subroutine call pushes two bytes
// - Push decrements, pull increments pointer
module ivs_ctrl
  import ivs_pkg::*;
#(
  parameter int NFLAGS = `IVS_NUM_FLAGS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [NFLAGS:1] pend,
  input wire ivs_req_s req,
  input wire logic [7:0] pc_lo,
  input wire logic [7:0] pc_hi,
  input wire logic [7:0] x_reg,
  input wire logic [7:0] acc,
  input wire logic [7:0] ccr,
  input wire logic sp_load,
  input wire logic [15:0] sp_load_val,
  output ivs_mem_s mem,
  output logic [15:0] sp,
  output logic [15:0] vec_addr,
  output logic [4:0] vec_src,
  output logic busy,
  output logic done,
  output logic [7:0] ram_rdata,
  output logic in_ram
);
  ivs_state_e state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [15:0] next_sp;
  logic [15:0] next_vec_addr;
  logic [4:0] next_vec_src;
  logic next_done;
  ivs_mem_s next_mem;
  logic [15:0] sel_addr;
  logic [4:0] sel_src;
  logic [7:0] push_byte;
  logic is_call;
  logic is_call_r, next_is_call;
  logic [15:0] ret_r, next_ret;

  // Vector of a flag index; address falls as flag rises
  function automatic logic [15:0] vec_of(input logic [4:0] f);
    case (f)
      5'd1: vec_of = `IVS_VEC_F01;
      5'd2: vec_of = `IVS_VEC_F02;
      5'd3: vec_of = `IVS_VEC_F03;
      5'd4: vec_of = `IVS_VEC_F04;
      5'd5: vec_of = `IVS_VEC_F05;
      5'd6: vec_of = `IVS_VEC_F06;
      5'd7: vec_of = `IVS_VEC_F07;
      5'd8: vec_of = `IVS_VEC_F08;
      5'd9: vec_of = `IVS_VEC_F09;
      5'd10: vec_of = `IVS_VEC_F10;
      5'd11: vec_of = `IVS_VEC_F11;
      5'd12: vec_of = `IVS_VEC_F12;
      5'd13: vec_of = `IVS_VEC_F13;
      5'd14: vec_of = `IVS_VEC_F14;
      5'd15: vec_of = `IVS_VEC_F15;
      5'd16: vec_of = `IVS_VEC_F16;
      5'd17: vec_of = `IVS_VEC_F17;
      5'd18: vec_of = `IVS_VEC_F18;
      5'd19: vec_of = `IVS_VEC_F19;
      5'd20: vec_of = `IVS_VEC_F20;
      5'd21: vec_of = `IVS_VEC_F21;
      default: vec_of = `IVS_VEC_RSVD;
    endcase
  endfunction

  // Lowest flag index pending wins: highest vector address
  always_comb begin
    sel_src = 5'd0;
    sel_addr = `IVS_VEC_RSVD;
    if (req.software_interrupt) begin
      sel_addr = `IVS_VEC_SOFTWARE_INT;
    end else begin
      for (int i = NFLAGS; i >= 1; i--) begin
        if (pend[i]) begin
          sel_src = 5'(i);
          sel_addr = vec_of(5'(i));
        end
      end
    end
  end

  assign is_call = req.call && !req.int_entry && !req.software_interrupt;

  // Byte pushed at each step: PCL, PCH, X, A, CCR; H omitted
  always_comb begin
    case (cnt)
      3'd0: push_byte = is_call_r ? ret_r[7:0] : pc_lo;
      3'd1: push_byte = is_call_r ? ret_r[15:8] : pc_hi;
      3'd2: push_byte = x_reg;
      3'd3: push_byte = acc;
      3'd4: push_byte = ccr;
      default: push_byte = 8'h00;
    endcase
  end

  // Stacking sequencer and stack pointer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sp = sp;
    next_vec_addr = vec_addr;
    next_vec_src = vec_src;
    next_done = 1'b0;
    next_is_call = is_call_r;
    next_ret = ret_r;
    next_mem = '0;
    case (state)
      IVS_IDLE: begin
        if (sp_load) begin
          next_sp = sp_load_val;
        end else if (req.int_entry || req.software_interrupt) begin
          next_state = IVS_PUSH;
          next_cnt = 3'd0;
          next_is_call = 1'b0;
          next_vec_addr = sel_addr;
          next_vec_src = sel_src;
        end else if (is_call) begin
          next_state = IVS_PUSH;
          next_cnt = 3'd0;
          next_is_call = 1'b1;
          next_ret = req.ret_addr;
        end else if (req.push) begin
          next_sp = sp - 16'h0001;
        end else if (req.pull) begin
          next_sp = sp + 16'h0001;
        end
      end
      IVS_PUSH: begin
        next_mem.wr = 1'b1;
        next_mem.addr = sp;
        next_mem.wdata = push_byte;
        next_sp = sp - 16'h0001;
        next_cnt = cnt + 3'd1;
        if (is_call_r && cnt == `IVS_CALL_STACK_BYTES - 3'd1) begin
          next_state = IVS_IDLE;
          next_done = 1'b1;
        end else if (!is_call_r && cnt == `IVS_INT_STACK_BYTES - 3'd1) begin
          next_state = IVS_VHI;
        end
      end
      IVS_VHI: begin
        next_mem.rd = 1'b1;
        next_mem.addr = vec_addr;
        next_state = IVS_VLO;
      end
      IVS_VLO: begin
        next_mem.rd = 1'b1;
        next_mem.addr = vec_addr + 16'h0001;
        next_state = IVS_IDLE;
        next_done = 1'b1;
      end
      default: next_state = IVS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= IVS_IDLE;
      cnt <= 3'd0;
      sp <= `IVS_SP_RESET;
      vec_addr <= `IVS_VEC_RESET;
      vec_src <= 5'd0;
      done <= 1'b0;
      is_call_r <= 1'b0;
      ret_r <= 16'h0000;
      mem <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sp <= next_sp;
      vec_addr <= next_vec_addr;
      vec_src <= next_vec_src;
      done <= next_done;
      is_call_r <= next_is_call;
      ret_r <= next_ret;
      mem <= next_mem;
    end
  end

  assign busy = (state != IVS_IDLE);

  // Page-zero RAM window: 0060..00FF
  logic ram_hit;
  logic ram_sel;
  logic [7:0] ram_idx;
  logic [7:0] last_idx, next_last_idx;
  assign ram_sel = (mem.wr || mem.rd) && mem.addr >= `IVS_RAM_BASE
    && mem.addr <= `IVS_PAGE0_TOP;
  assign ram_hit = ram_sel && mem.wr;
  // Off-window cycles keep the last RAM index, so reads stay in range
  assign ram_idx = ram_sel ? 8'(mem.addr - `IVS_RAM_BASE) : last_idx;
  assign next_last_idx = ram_idx;
  assign in_ram = (sp >= `IVS_RAM_BASE);

  // Last RAM index, starts at the reset stack top
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_idx <= 8'(`IVS_SP_RESET - `IVS_RAM_BASE);
    end else begin
      last_idx <= next_last_idx;
    end
  end

  ivs_ram #(.DEPTH(`IVS_PAGE0_RAM_BYTES), .AW(8)) u_ram (
    .clk(clk),
    .we(ram_hit),
    .addr(ram_idx),
    .wdata(mem.wdata),
    .rdata(ram_rdata)
  );

  // Counts bytes written since entry for checking
  logic [2:0] wr_seen, next_wr_seen;
  always_comb begin
    next_wr_seen = wr_seen;
    if (state == IVS_IDLE) begin
      next_wr_seen = 3'h0;
    end else if (mem.wr) begin
      next_wr_seen = wr_seen + 3'h1;
    end
  end

  // Write counter register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_seen <= 3'h0;
    end else begin
      wr_seen <= next_wr_seen;
    end
  end

  sp_reset_a: assert property (@(posedge clk) $rose(rst_b) |-> sp == `IVS_SP_RESET)
    else $error("stack pointer not at reset value");
  five_push_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IVS_VHI) |-> (cnt == `IVS_INT_STACK_BYTES))
    else $error("interrupt entry did not push five bytes");
  int_seq_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IVS_IDLE && !sp_load && req.int_entry) |=> (sp == $past(sp))
    ##5 (sp == $past(sp, 6) - 16'h0005))
    else $error("interrupt stacking moved pointer wrongly");
  call_two_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IVS_IDLE && !sp_load && is_call && !req.int_entry) |=> ##2
    (sp == $past(sp, 3) - 16'h0002 && done))
    else $error("call did not push two bytes");
  push_dec_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IVS_IDLE && !sp_load && !req.int_entry && !req.software_interrupt
    && !req.call && req.push) |=> sp == $past(sp) - 16'h0001)
    else $error("push did not decrement pointer");
  pull_inc_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IVS_IDLE && !sp_load && !req.int_entry && !req.software_interrupt
    && !req.call && !req.push && req.pull) |=> sp == $past(sp) + 16'h0001)
    else $error("pull did not increment pointer");
  tmr_vec_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IVS_IDLE && !sp_load && req.int_entry && !req.software_interrupt
    && pend[6] && pend[5:1] == '0) |=> vec_addr == 16'hFFF0)
    else $error("first timer overflow vector wrong");
  prio_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IVS_IDLE && !sp_load && req.int_entry && !req.software_interrupt
    && pend[4] && pend[3:1] == '0) |=> vec_addr == 16'hFFF4 && vec_src == 5'h04)
    else $error("priority selection wrong");
  vec_fetch_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IVS_VLO) |=> mem.rd && mem.addr == vec_addr + 16'h0001 && done)
    else $error("vector low byte fetch wrong");
  hreg_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IVS_VHI) |-> wr_seen == 3'h4)
    else $error("extra byte stacked");
  vec_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IVS_VHI || state == IVS_VLO) |=> $stable(sp))
    else $error("pointer moved during vector fetch");
endmodule

// ---- tb/ivs_core_model.sv ----
`timescale 1ns/1ns
module ivs_core_model
  import ivs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] kind,
  output ivs_req_s req,
  output logic [7:0] pc_lo,
  output logic [7:0] pc_hi,
  output logic [7:0] x_reg,
  output logic [7:0] acc,
  output logic [7:0] ccr
);
  // Fixed context, stable for the whole stacking sequence
  assign pc_lo = 8'h1A;
  assign pc_hi = 8'h2B;
  assign x_reg = 8'h3C;
  assign acc = 8'h4D;
  assign ccr = 8'h5E;
  // One request per command code: 1 int, 2 soft int, 3 call, 4 push, 5 pull
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req <= '0;
    end else begin
      req.int_entry <= (kind == 3'h1);
      req.software_interrupt <= (kind == 3'h2);
      req.call <= (kind == 3'h3);
      req.push <= (kind == 3'h4);
      req.pull <= (kind == 3'h5);
      req.ret_addr <= 16'hC0DE;
    end
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench
  import ivs_pkg::*;
;
  `define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); n_fail++; end end
  logic clk, rst_b, sp_load, busy, done, in_ram;
  logic [21:1] pend;
  logic [2:0] kind;
  logic [15:0] sp_load_val, sp, vec_addr, sp0;
  logic [4:0] vec_src;
  logic [7:0] pc_lo, pc_hi, x_reg, acc, ccr, ram_rdata;
  ivs_req_s req;
  ivs_mem_s mem;
  logic [15:0] wa[$], ra[$];
  logic [7:0] wd[$];
  logic [7:0] ctx[5] = '{8'h1A, 8'h2B, 8'h3C, 8'h4D, 8'h5E};
  int n_fail = 0;
  int n_compared = 0;

  ivs_core_model core (.clk(clk), .rst_b(rst_b), .kind(kind), .req(req), .pc_lo(pc_lo),
    .pc_hi(pc_hi), .x_reg(x_reg), .acc(acc), .ccr(ccr));
  ivs_ctrl dut (.clk(clk), .rst_b(rst_b), .pend(pend), .req(req), .pc_lo(pc_lo),
    .pc_hi(pc_hi), .x_reg(x_reg), .acc(acc), .ccr(ccr), .sp_load(sp_load),
    .sp_load_val(sp_load_val), .mem(mem), .sp(sp), .vec_addr(vec_addr), .vec_src(vec_src),
    .busy(busy), .done(done), .ram_rdata(ram_rdata), .in_ram(in_ram));

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Verdict and end of run
  task automatic finish_test;
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Issue one command and log the memory traffic until done
  task automatic run(input logic [2:0] k);
    wa.delete();
    wd.delete();
    ra.delete();
    sp0 = sp;
    @(posedge clk);
    kind <= k;
    @(posedge clk);
    kind <= 3'h0;
    for (int c = 0; c < 12; c++) begin
      @(posedge clk);
      #1;
      if (mem.wr === 1'b1) begin
        wa.push_back(mem.addr);
        wd.push_back(mem.wdata);
      end
      if (mem.rd === 1'b1) ra.push_back(mem.addr);
      if (done === 1'b1) break;
    end
  endtask

  // Load the stack pointer
  task automatic ld(input logic [15:0] v);
    @(posedge clk);
    sp_load <= 1'b1;
    sp_load_val <= v;
    @(posedge clk);
    sp_load <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Interrupt entry: five bytes stacked, then the two vector bytes
  task automatic t_int(input logic [21:1] p, input logic [2:0] k, input logic [15:0] ev,
    input logic [4:0] es);
    @(posedge clk);
    pend <= p;
    run(k);
    `CHK("stk_count", 5, wa.size())
    for (int j = 0; j < 5; j++) begin
      `CHK("stk_addr", sp0 - 16'(j), wa[j])
      `CHK("stk_data", ctx[j], wd[j])
    end
    `CHK("sp_after_int", sp0 - 16'h0005, sp)
    `CHK("vec_addr", ev, vec_addr)
    `CHK("vec_hi", ev, ra[0])
    `CHK("vec_lo", ev + 16'h0001, ra[1])
    `CHK("vec_src", es, vec_src)
    `CHK("ram_top", ctx[4], ram_rdata)
    pend <= '0;
    ld(16'h00FF);
  endtask

  // Call, push and pull move the pointer downward then back
  task automatic t_call;
    run(3'h3);
    `CHK("call_count", 2, wa.size())
    `CHK("call_addr", sp0 - 16'h0001, wa[1])
    `CHK("call_lo", 8'hDE, wd[0])
    `CHK("call_hi", 8'hC0, wd[1])
    `CHK("sp_after_call", sp0 - 16'h0002, sp)
    run(3'h4);
    `CHK("sp_push", sp0 - 16'h0001, sp)
    `CHK("ram_call", 8'hC0, ram_rdata)
    run(3'h5);
    `CHK("sp_pull", sp0 + 16'h0001, sp)
  endtask

  // A push raised while stacking is ignored
  task automatic t_busy;
    sp0 = sp;
    @(posedge clk);
    kind <= 3'h1;
    @(posedge clk);
    kind <= 3'h4;
    repeat (2) @(posedge clk);
    #1;
    `CHK("busy_mid", 1'b1, busy)
    @(posedge clk);
    kind <= 3'h0;
    repeat (8) @(posedge clk);
    #1;
    `CHK("sp_refused", sp0 - 16'h0005, sp)
    `CHK("busy_end", 1'b0, busy)
    ld(16'h00FF);
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    pend = '0;
    kind = 3'h0;
    sp_load = 1'b0;
    sp_load_val = 16'h0000;
    repeat (4) @(posedge clk);
    #1;
    `CHK("sp_reset", 16'h00FF, sp)
    `CHK("vec_reset", 16'hFFFE, vec_addr)
    `CHK("busy_reset", 1'b0, busy)
    @(posedge clk);
    rst_b <= 1'b1;
    ld(16'h005F);
    `CHK("below_ram", 1'b0, in_ram)
    ld(16'h0400);
    `CHK("sp_wide", 16'h0400, sp)
    `CHK("in_ram", 1'b1, in_ram)
    ld(16'h00FF);
    for (int i = 1; i <= 21; i++) begin
      t_int(21'h0_0001 << (i - 1), 3'h1, 16'hFFFC - 16'(2 * i), 5'(i));
    end
    t_int(21'h0_0104, 3'h1, 16'hFFF6, 5'h03);
    t_int(21'h0_0004, 3'h2, 16'hFFFC, 5'h00);
    t_call;
    t_busy;
    finish_test;
  end

  // Watchdog against a hang
  initial begin
    #12000;
    n_fail++;
    finish_test;
  end
endmodule
